// file: logic/ssw_mode_fsm.sv
// What this block does
// [RULE1] Enable and diagnostic-enable both low sends the device to standby-delay.
// [RULE2] After the standby delay, both still low, move to standby.
// [RULE3] Standby draws least power and offers no diagnostics.
// [RULE4] Diagnostic state runs diagnostics with the output switch off.
// [RULE5] Active turns the switch on; diagnostics toggle independently.
// [RULE6] Thermal shutdown or current limit forces the fault state from active or diagnostic.
// [RULE7] Leave fault only when faults clear, hold low and retry timer expired.
// [RULE8] On leaving fault, switch on if enable high, else stay off.
// [RULE9] Lost ground turns the switch off; normal operation resumes afterwards.
// [RULE10] Reverse current is never flagged and changes nothing.
// [RULE11] Host samples sense only after the settle time following turn-on.
// [RULE12] Open-load flag clears on diagnostic-enable fall or enable rise.
// [RULE13] With switch on, only overcurrent or overtemperature are flagged.
// [RULE14] Standby delay and retry time are programmable values.
// [RULE15] A new fault in active or diagnostic wins over any other move.
`timescale 1ns/10ps
module ssw_mode_fsm
(
    // clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  srst,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic                       pready,
    output logic                       pslverr,
    output logic [31:0]                prdata,
    // analog side events
    input  ssw_pkg::ssw_event_type     events,
    input  wire logic                  reverse_current,
    // power stage and sense
    output logic                       switch_on,
    output logic                       diag_active,
    output logic                       sense_output_en,
    output logic                       sense_fault_level,
    output logic                       sense_temperature,
    output logic                       sense_valid,
    output logic                       low_power
);
    import ssw_pkg::*;

    ssw_ctrl_type  ctrl;
    ssw_state_type state_reg;
    ssw_state_type state_next;
    logic [31:0]   stby_limit;
    logic [31:0]   retry_limit;
    logic [31:0]   settle_limit;
    logic [31:0]   status_word;
    logic          enable_d_reg;
    logic          diag_d_reg;
    logic          open_load_reg;
    logic          shutdown_fault;
    logic          stby_expired;
    logic          retry_expired;
    logic          settle_expired;
    logic          switch_next;
    logic          enable_rise;
    logic          diag_fall;
    logic          fault_detect;

    //////////////////////////////////////////////////////////////////////
    // register file

    ssw_apb_regs u_regs
    (
        .core_clk     (core_clk),
        .srst         (srst),
        .psel         (psel),
        .penable      (penable),
        .pwrite       (pwrite),
        .paddr        (paddr),
        .pwdata       (pwdata),
        .pready       (pready),
        .pslverr      (pslverr),
        .prdata       (prdata),
        .status_word  (status_word),
        .ctrl         (ctrl),
        .stby_limit   (stby_limit),
        .retry_limit  (retry_limit),
        .settle_limit (settle_limit)
    );

    assign status_word = {24'h00_0000, sense_valid, open_load_reg, shutdown_fault, switch_on,
                          1'b0, state_reg};

    //////////////////////////////////////////////////////////////////////
    // timers

    ssw_timer u_stby_timer
    (
        .core_clk (core_clk),
        .srst     (srst),
        .restart  (1'b0),
        .run      (state_reg == SSW_ST_STANDBY_DELAY),
        .limit    (stby_limit),        // RULE14
        .expired  (stby_expired)
    );

    ssw_timer u_retry_timer
    (
        .core_clk (core_clk),
        .srst     (srst),
        .restart  (shutdown_fault),    // retry counts from the last fault seen
        .run      (state_reg == SSW_ST_FAULT),
        .limit    (retry_limit),       // RULE14
        .expired  (retry_expired)
    );

    ssw_timer u_settle_timer
    (
        .core_clk (core_clk),
        .srst     (srst),
        .restart  (1'b0),
        .run      (switch_on),
        .limit    (settle_limit),
        .expired  (settle_expired)
    );

    //////////////////////////////////////////////////////////////////////
    // edges and fault detection

    // reverse current deliberately feeds nothing here
    assign shutdown_fault = events.thermal_shutdown || events.current_limit; // RULE6 RULE10
    assign enable_rise    = ctrl.enable && !enable_d_reg;
    assign diag_fall      = !ctrl.diagnostic_enable && diag_d_reg;

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            enable_d_reg <= 1'b0;
            diag_d_reg   <= 1'b0;
        end
        else
        begin
            enable_d_reg <= ctrl.enable;
            diag_d_reg   <= ctrl.diagnostic_enable;
        end
    end

    // open load only watched with switch off and diagnostics on; edges clear it
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            open_load_reg <= 1'b0;
        end
        else if (enable_rise || diag_fall)
        begin
            open_load_reg <= 1'b0; // RULE12
        end
        else if (ctrl.diagnostic_enable && !ctrl.enable && state_reg != SSW_ST_ACTIVE)
        begin
            open_load_reg <= events.open_load;
        end
        else if (switch_on)
        begin
            open_load_reg <= 1'b0; // RULE13
        end
    end

    //////////////////////////////////////////////////////////////////////
    // mode state machine

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            SSW_ST_STANDBY_DELAY:
            begin
                if (ctrl.enable)
                    state_next = SSW_ST_ACTIVE;
                else if (ctrl.diagnostic_enable)
                    state_next = SSW_ST_DIAGNOSTIC;
                else if (stby_expired)
                    state_next = SSW_ST_STANDBY; // RULE2
            end
            SSW_ST_STANDBY:
            begin
                if (ctrl.enable)
                    state_next = SSW_ST_ACTIVE;
                else if (ctrl.diagnostic_enable)
                    state_next = SSW_ST_DIAGNOSTIC;
            end
            SSW_ST_DIAGNOSTIC:
            begin
                if (shutdown_fault)
                    state_next = SSW_ST_FAULT; // RULE15
                else if (ctrl.enable)
                    state_next = SSW_ST_ACTIVE;
                else if (!ctrl.diagnostic_enable)
                    state_next = SSW_ST_STANDBY_DELAY; // RULE1
            end
            SSW_ST_ACTIVE:
            begin
                if (shutdown_fault)
                    state_next = SSW_ST_FAULT; // RULE6 RULE15
                else if (!ctrl.enable && !ctrl.diagnostic_enable)
                    state_next = SSW_ST_STANDBY_DELAY; // RULE1
                else if (!ctrl.enable)
                    state_next = SSW_ST_DIAGNOSTIC;
            end
            SSW_ST_FAULT:
            begin
                if (!shutdown_fault && !ctrl.fault_hold && retry_expired) // RULE7
                begin
                    if (ctrl.enable)
                        state_next = SSW_ST_ACTIVE; // RULE8
                    else if (ctrl.diagnostic_enable)
                        state_next = SSW_ST_DIAGNOSTIC;
                    else
                        state_next = SSW_ST_STANDBY_DELAY;
                end
            end
            default:
            begin
                state_next = SSW_ST_STANDBY_DELAY;
            end
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
            state_reg <= SSW_ST_STANDBY_DELAY;
        else
            state_reg <= state_next;
    end

    //////////////////////////////////////////////////////////////////////
    // outputs, all registered

    // ground loss overrides the switch without disturbing the mode
    assign switch_next  = (state_next == SSW_ST_ACTIVE) && !events.ground_lost; // RULE5 RULE8 RULE9
    assign fault_detect = (state_reg == SSW_ST_FAULT) || open_load_reg;

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            switch_on         <= 1'b0;
            diag_active       <= 1'b0;
            sense_output_en   <= 1'b0;
            sense_fault_level <= 1'b0;
            sense_temperature <= 1'b0;
            low_power         <= 1'b0;
        end
        else
        begin
            switch_on         <= switch_next;
            // diagnostic state keeps the switch off but diagnostics live
            diag_active       <= ctrl.diagnostic_enable && (state_next != SSW_ST_STANDBY)
                              && (state_next != SSW_ST_STANDBY_DELAY); // RULE3 RULE4 RULE5
            sense_output_en   <= ctrl.diagnostic_enable && (state_next != SSW_ST_STANDBY); // RULE3
            sense_fault_level <= ctrl.diagnostic_enable && !ctrl.sense_select && fault_detect; // RULE13
            sense_temperature <= ctrl.diagnostic_enable && ctrl.sense_select;
            low_power         <= state_next == SSW_ST_STANDBY; // RULE3
        end
    end

    // readiness hint for host sampling after turn-on settle
    always_ff @(posedge core_clk)
    begin
        if (srst)
            sense_valid <= 1'b0;
        else
            sense_valid <= switch_next && settle_expired; // RULE11
    end

endmodule // ssw_mode_fsm

// file: logic/ssw_pkg.sv
package ssw_pkg;

    // register byte offsets
    localparam logic [11:0] SSW_CTRL_OFS   = 12'h000;
    localparam logic [11:0] SSW_STATUS_OFS = 12'h004;
    localparam logic [11:0] SSW_STBY_OFS   = 12'h008;
    localparam logic [11:0] SSW_RETRY_OFS  = 12'h00C;
    localparam logic [11:0] SSW_SETTLE_OFS = 12'h010;

    // control register fields
    localparam int SSW_CTRL_EN_BIT   = 0;
    localparam int SSW_CTRL_DIAG_BIT = 1;
    localparam int SSW_CTRL_HOLD_BIT = 2;
    localparam int SSW_CTRL_SEL_BIT  = 3;

    // timing, in microseconds, and cycles at 20 MHz
    localparam int SSW_CLK_MHZ            = 20;
    localparam int SSW_STBY_DELAY_US      = 1000;
    localparam int SSW_RETRY_US           = 2000;
    localparam int SSW_SETTLE_US          = 10;
    localparam logic [31:0] SSW_STBY_CYC  = 32'(SSW_STBY_DELAY_US * SSW_CLK_MHZ);
    localparam logic [31:0] SSW_RETRY_CYC = 32'(SSW_RETRY_US * SSW_CLK_MHZ);
    localparam logic [31:0] SSW_SETTLE_CYC = 32'(SSW_SETTLE_US * SSW_CLK_MHZ);

    localparam logic [31:0] SSW_ZERO_WORD = 32'h0000_0000;

    typedef enum logic [2:0] {
        SSW_ST_STANDBY_DELAY,
        SSW_ST_STANDBY,
        SSW_ST_DIAGNOSTIC,
        SSW_ST_ACTIVE,
        SSW_ST_FAULT
    } ssw_state_type;

    // analog-side fault events into the block
    typedef struct packed {
        logic thermal_shutdown;
        logic current_limit;
        logic open_load;
        logic ground_lost;
    } ssw_event_type;

    // control inputs the state machine acts on
    typedef struct packed {
        logic enable;
        logic diagnostic_enable;
        logic fault_hold;
        logic sense_select;
    } ssw_ctrl_type;

endpackage

// file: logic/ssw_timer.sv
`timescale 1ns/10ps
module ssw_timer
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        srst,
    // control
    input  wire logic        restart,
    input  wire logic        run,
    input  wire logic [31:0] limit,
    // status
    output logic             expired
);
    import ssw_pkg::*;

    logic [31:0] count_reg;

    //////////////////////////////////////////////////////////////////////
    // counts while run; a restart reloads so a stale count never leaks
    always_ff @(posedge core_clk)
    begin
        if (srst || restart || !run)
        begin
            count_reg <= SSW_ZERO_WORD;
        end
        else if (count_reg < limit)
        begin
            count_reg <= count_reg + 32'h0000_0001;
        end
    end

    assign expired = run && !restart && (count_reg >= limit);

endmodule // ssw_timer

// file: logic/ssw_apb_regs.sv
`timescale 1ns/10ps
module ssw_apb_regs
(
    // clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  srst,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic                       pready,
    output logic                       pslverr,
    output logic [31:0]                prdata,
    // block side
    input  wire logic [31:0]           status_word,
    output ssw_pkg::ssw_ctrl_type      ctrl,
    output logic [31:0]                stby_limit,
    output logic [31:0]                retry_limit,
    output logic [31:0]                settle_limit
);
    import ssw_pkg::*;

    logic [3:0]  ctrl_reg;
    logic [31:0] stby_reg;
    logic [31:0] retry_reg;
    logic [31:0] settle_reg;
    logic        access;
    logic        mapped;

    assign access = psel && penable;
    assign mapped = (paddr == SSW_CTRL_OFS) || (paddr == SSW_STATUS_OFS) || (paddr == SSW_STBY_OFS)
                 || (paddr == SSW_RETRY_OFS) || (paddr == SSW_SETTLE_OFS);

    //////////////////////////////////////////////////////////////////////
    // zero wait state: pready answers in the access phase itself
    assign pready  = 1'b1;
    assign pslverr = access && !mapped;

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            ctrl_reg   <= 4'h0;
            stby_reg   <= SSW_STBY_CYC;
            retry_reg  <= SSW_RETRY_CYC;
            settle_reg <= SSW_SETTLE_CYC;
        end
        else if (access && pwrite)
        begin
            case (paddr)
                SSW_CTRL_OFS:   ctrl_reg   <= pwdata[3:0];
                SSW_STBY_OFS:   stby_reg   <= pwdata;
                SSW_RETRY_OFS:  retry_reg  <= pwdata;
                SSW_SETTLE_OFS: settle_reg <= pwdata;
                default:        ctrl_reg   <= ctrl_reg;
            endcase
        end
    end

    always_comb
    begin
        case (paddr)
            SSW_CTRL_OFS:   prdata = {28'h000_0000, ctrl_reg};
            SSW_STATUS_OFS: prdata = status_word;
            SSW_STBY_OFS:   prdata = stby_reg;
            SSW_RETRY_OFS:  prdata = retry_reg;
            SSW_SETTLE_OFS: prdata = settle_reg;
            default:        prdata = SSW_ZERO_WORD;
        endcase
    end

    assign ctrl.enable            = ctrl_reg[SSW_CTRL_EN_BIT];
    assign ctrl.diagnostic_enable = ctrl_reg[SSW_CTRL_DIAG_BIT];
    assign ctrl.fault_hold        = ctrl_reg[SSW_CTRL_HOLD_BIT];
    assign ctrl.sense_select      = ctrl_reg[SSW_CTRL_SEL_BIT];
    assign stby_limit             = stby_reg;
    assign retry_limit            = retry_reg;
    assign settle_limit           = settle_reg;

endmodule // ssw_apb_regs

// file: dv/ssw_mode_fsm_checker.sv
`timescale 1ns/10ps
module ssw_mode_fsm_checker
(
    // clock and reset
    input wire logic                  core_clk,
    input wire logic                  srst,
    // watched ports
    input wire logic                  psel,
    input wire logic                  pslverr,
    input wire ssw_pkg::ssw_event_type events,
    input wire logic                  reverse_current,
    input wire logic                  switch_on,
    input wire logic                  diag_active,
    input wire logic                  sense_output_en,
    input wire logic                  sense_valid,
    input wire logic                  low_power
);
    import ssw_pkg::*;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);
////////////////////////////////////////////////////////////////////////////////
    AST_FAULT_OFF: assert property ((events.thermal_shutdown || events.current_limit) |=> !switch_on)
        else $error("switch stayed on under a shutdown fault");
    AST_RETRY_WAIT: assert property (($fell(events.thermal_shutdown) && !switch_on) |=> !switch_on [*2])
        else $error("switch back on before the retry time");
    AST_GND_OFF: assert property (events.ground_lost |=> !switch_on)
        else $error("switch on while ground is lost");
    AST_STBY_QUIET: assert property (low_power |-> !switch_on && !diag_active && !sense_output_en)
        else $error("standby with switch or diagnostics alive");
    AST_STBY_ENTRY: assert property ($rose(low_power) |-> $past(switch_on, 4) == 1'b0)
        else $error("standby entered without the delay");
    AST_VALID_LATE: assert property ($rose(switch_on) |-> !sense_valid)
        else $error("sense valid at switch turn-on");
    AST_VALID_ON: assert property (sense_valid |-> switch_on && $past(switch_on))
        else $error("sense valid with switch off");
    // write lands one edge after psel, so two quiet edges are needed
    AST_REVERSE: assert property ((reverse_current && switch_on && events == 4'h0 && !psel && !$past(psel))
        |=> switch_on)
        else $error("reverse current disturbed the switch");
    cover property ($rose(low_power));
    cover property ($fell(switch_on) && events.thermal_shutdown);
    cover property (pslverr);
endmodule // ssw_mode_fsm_checker

bind ssw_mode_fsm ssw_mode_fsm_checker u_chk (.core_clk(core_clk), .srst(srst), .psel(psel), .pslverr(pslverr),
    .events(events), .reverse_current(reverse_current), .switch_on(switch_on), .diag_active(diag_active),
    .sense_output_en(sense_output_en), .sense_valid(sense_valid), .low_power(low_power));

// file: dv/ssw_host_adc.sv
`timescale 1ns/10ps
module ssw_host_adc
(
    // clock and reset
    input  wire logic core_clk,
    input  wire logic srst,
    // sense side
    input  wire logic sense_valid,
    input  wire logic sense_output_en,
    // result
    output int        samples
);
    // an early sample would read a sense line still settling
    always_ff @(posedge core_clk)
    begin
        if (srst)
            samples <= 0;
        else if (sense_valid && sense_output_en)
            samples <= samples + 1;
    end
endmodule // ssw_host_adc

// file: dv/ssw_mode_fsm_tb_top.sv
`timescale 1ns/10ps
module ssw_mode_fsm_tb_top;
    import ssw_pkg::*;
    logic          core_clk, srst, psel, penable, pwrite, pready, pslverr, reverse_current;
    logic [11:0]   paddr;
    logic [31:0]   pwdata, prdata, rd;
    ssw_event_type ev;
    logic          switch_on, diag_active, sense_output_en, sense_fault_level, sense_temperature;
    logic          sense_valid, low_power;
    int            n_mismatch, compares, cyc, m_state, samples, c;
    logic [11:0]   lim_ofs [3] = '{SSW_STBY_OFS, SSW_RETRY_OFS, SSW_SETTLE_OFS};
////////////////////////////////////////////////////////////////////////////////
    ssw_mode_fsm dut (.core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata), .events(ev),
        .reverse_current(reverse_current), .switch_on(switch_on), .diag_active(diag_active),
        .sense_output_en(sense_output_en), .sense_fault_level(sense_fault_level),
        .sense_temperature(sense_temperature), .sense_valid(sense_valid), .low_power(low_power));
    ssw_host_adc u_host (.core_clk(core_clk), .srst(srst), .sense_valid(sense_valid),
        .sense_output_en(sense_output_en), .samples(samples));
////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // reverse current toggles freely all run
    always @(posedge core_clk)
    begin
        reverse_current <= 1'($urandom % 2);
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            n_mismatch++;
            complete_run;
        end
    end
////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("mismatches=%0d compares=%0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic err);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do
            @(posedge core_clk);
        while (pready !== 1'b1);
        rd = prdata;
        chk({31'h0, pslverr}, {31'h0, err});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // model of the mode reached from a control word outside fault
    task automatic setc(input int v);
        c = v;
        apb(1'b1, SSW_CTRL_OFS, 32'(v), 1'b0);
        if (m_state != 4)
            m_state = (v & 1) ? 3 : ((v & 2) ? 2 : 0);
    endtask
    task automatic chk_state;
        apb(1'b0, SSW_STATUS_OFS, 32'h0000_0000, 1'b0);
        chk({29'h0, rd[2:0]}, 32'(m_state));
        chk({31'h0, rd[4]}, {31'h0, m_state == 3});
    endtask
    task automatic wsw(input logic v, input int n);
        for (int i = 0; i < n && switch_on !== v; i++)
            tick(1);
        chk({31'h0, switch_on}, {31'h0, v});
    endtask
////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        void'($urandom(24));
        {psel, penable, pwrite, paddr, pwdata, ev, reverse_current} = '0;
        {n_mismatch, compares, cyc, m_state} = '0;
        srst = 1'b1;
        repeat (8) @(posedge core_clk);
        srst <= 1'b0;
        apb(1'b0, SSW_CTRL_OFS, 32'h0000_0000, 1'b0);
        chk(rd, SSW_ZERO_WORD);
        apb(1'b0, SSW_STBY_OFS, 32'h0000_0000, 1'b0);
        chk(rd, SSW_STBY_CYC);
        apb(1'b0, SSW_RETRY_OFS, 32'h0000_0000, 1'b0);
        chk(rd, SSW_RETRY_CYC);
        chk_state;
        apb(1'b1, 12'h020, 32'hFFFF_FFFF, 1'b1);
        apb(1'b0, 12'h020, 32'h0000_0000, 1'b1);
        chk(rd, SSW_ZERO_WORD);
        // short limits keep the run small
        foreach (lim_ofs[i])
        begin
            apb(1'b1, lim_ofs[i], 32'h0000_0005, 1'b0);
            apb(1'b0, lim_ofs[i], 32'h0000_0000, 1'b0);
            chk(rd, 32'h0000_0005);
        end
        tick(10);
        m_state = 1;
        chk_state;
        chk({31'h0, low_power}, 32'h0000_0001);
        setc(3);
        wsw(1'b1, 2);
        chk({31'h0, sense_valid}, 32'h0000_0000);
        tick(8);
        chk({31'h0, sense_valid}, 32'h0000_0001);
        chk(32'(samples != 0), 32'h0000_0001);
        repeat (6)
        begin
            setc(1 | (($urandom % 2) << 1) | (($urandom % 2) << 3));
            tick(2);
            chk({31'h0, switch_on}, 32'h0000_0001);
            chk({31'h0, diag_active}, 32'((c >> 1) & 1));
            chk({31'h0, sense_output_en}, 32'((c >> 1) & 1));
            chk({31'h0, sense_temperature}, 32'((c >> 1) & (c >> 3) & 1));
        end
        chk_state;
        setc(5);
        @(posedge core_clk);
        ev.thermal_shutdown <= 1'b1;
        wsw(1'b0, 3);
        m_state = 4;
        chk_state;
        chk({31'h0, rd[5]}, 32'h0000_0001);
        ev.thermal_shutdown <= 1'b0;
        tick(20);
        chk({31'h0, switch_on}, 32'h0000_0000);
        setc(1);
        wsw(1'b1, 12);
        m_state = 3;
        chk_state;
        @(posedge core_clk);
        ev.current_limit <= 1'b1;
        wsw(1'b0, 3);
        m_state = 4;
        setc(2);
        ev.current_limit <= 1'b0;
        // retry of five cycles still running when the status is taken
        tick(2);
        chk_state;
        tick(20);
        chk({31'h0, switch_on}, 32'h0000_0000);
        m_state = 2;
        chk_state;
        setc(1);
        wsw(1'b1, 3);
        @(posedge core_clk);
        ev.ground_lost <= 1'b1;
        wsw(1'b0, 3);
        ev.ground_lost <= 1'b0;
        wsw(1'b1, 3);
        setc(2);
        ev.open_load <= 1'b1;
        tick(3);
        apb(1'b0, SSW_STATUS_OFS, 32'h0000_0000, 1'b0);
        chk({31'h0, rd[6]}, 32'h0000_0001);
        setc(0);
        apb(1'b0, SSW_STATUS_OFS, 32'h0000_0000, 1'b0);
        chk({31'h0, rd[6]}, 32'h0000_0000);
        setc(2);
        tick(3);
        setc(3);
        tick(2);
        apb(1'b0, SSW_STATUS_OFS, 32'h0000_0000, 1'b0);
        chk({31'h0, rd[6]}, 32'h0000_0000);
        chk({31'h0, sense_fault_level}, 32'h0000_0000);
        ev.open_load <= 1'b0;
        setc(0);
        chk_state;
        tick(12);
        m_state = 1;
        chk_state;
        chk({31'h0, diag_active}, 32'h0000_0000);
        complete_run;
    end
endmodule // ssw_mode_fsm_tb_top
